// [dbgef_defines.vh]
// Constants for the debug error flag and security gate block
`ifndef DBGEF_DEFINES_VH
`define DBGEF_DEFINES_VH

// Status low byte bit positions
`define DBGEF_BIT_ILLEGAL_COMMAND_POS 0
`define DBGEF_BIT_ILLEGAL_ACCESS_POS 1
`define DBGEF_BIT_READ_INVALID_POS 2
`define DBGEF_BIT_NORSP_POS 3

// Filler byte returned on failed or illegal accesses
`define DBGEF_FILL_BYTE 8'hEE

// Free bus cycle wait limit in core clocks
`define DBGEF_TMO_CYCLES 10'h200
`define DBGEF_TMO_W 10

// Width of the long acknowledge pulse in core clocks
`define DBGEF_LACK_CYCLES 4'h8
`define DBGEF_LACK_W 4

// Command class codes
`define DBGEF_CLS_ALWAYS 2'h0
`define DBGEF_CLS_NONINT 2'h1
`define DBGEF_CLS_ACTIVE 2'h2

// Access sequencer states
`define DBGEF_ST_IDLE 2'h0
`define DBGEF_ST_WAIT 2'h1
`define DBGEF_ST_HOLD 2'h2

`endif

// [dbgef_cmd_check.v]
// Command legality check: decides the illegal command conditions
`timescale 1ns/1ps
`include "dbgef_defines.vh"

module dbgef_cmd_check (
    input wire clk,
    input wire rst_n,
    input wire cmd_valid,
    input wire [1:0] cmd_class,
    input wire cmd_unimpl,
    input wire cmd_seq_bad,
    input wire ctrl_enabled,
    input wire bdm_active_flag,
    input wire erase_busy,
    input wire secure,
    output reg illegal_r
);

    reg illegal_nxt;

    // Any of the four refusal causes marks the command illegal
    always @* begin
        illegal_nxt = 1'b0;
        if (cmd_valid) begin
            if (cmd_unimpl || cmd_seq_bad)
                illegal_nxt = 1'b1;
            if (cmd_class == `DBGEF_CLS_ACTIVE && !bdm_active_flag)
                illegal_nxt = 1'b1;
            if (cmd_class != `DBGEF_CLS_ALWAYS && (!ctrl_enabled || erase_busy || secure))
                illegal_nxt = 1'b1;
        end
    end

    // Registered so the top sees a one-cycle verdict pulse
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            illegal_r <= 1'b0;
        end else begin
            illegal_r <= illegal_nxt;
        end
    end

endmodule

// [dbgef_timeout.v]
// Free bus cycle timeout counter
`timescale 1ns/1ps
`include "dbgef_defines.vh"

module dbgef_timeout (
    input wire clk,
    input wire rst_n,
    input wire run,
    output reg expired_r
);

    reg [`DBGEF_TMO_W-1:0] cnt_r;

    // Counts while the access waits; restarts whenever waiting stops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {`DBGEF_TMO_W{1'b0}};
            expired_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= {`DBGEF_TMO_W{1'b0}};
            expired_r <= 1'b0;
        end else begin
            if (cnt_r != `DBGEF_TMO_CYCLES - 10'h001)
                cnt_r <= cnt_r + 10'h001;
            expired_r <= (cnt_r == `DBGEF_TMO_CYCLES - 10'h001);
        end
    end

endmodule

// [dbgef_core.v]
// Debug error flags, filler data and security gate, top level
//
// Summary of operation
// - No free cycle in 512 clocks with handshake sets no_response
// - Early host retrieval sets no_response when unacknowledged
// - Unfinished write at next command sets no_response
// - Stop-mode memory or command access without clock sets no_response
// - Abort on error unless external wait holds
// - Background command in wait: flag, no abort
// - Register commands in wait re-set no_response
// - Command before wait return sets no_response
// - Step entering wait sets no_response when ctrl_enabled
// - No_response returns 0xEE per data byte
// - Writing one clears a flag; zero keeps
// - ECC read error sets read_invalid, data kept
// - Unimplemented, flash write, bad register: illegal_access
// - Illegal access returns 0xEE per byte
// - Unimplemented or misordered command: illegal_command
// - Active-only command outside background: illegal_command
// - Restricted command when disabled, erasing, secure: illegal
// - Illegal read command returns 0xEE bytes
// - Secure reset clears unsecure; access restricted
// - Good mass erase unsecures, sets unsecure_flag
// - Failed mass erase keeps device secure
// - Timeout abort with acknowledge sends long pulse
`timescale 1ns/1ps
`include "dbgef_defines.vh"

module dbgef_core (
    input wire clk,
    input wire rst_n,
    // Command arrival from the serial front end
    input wire cmd_valid,
    input wire [1:0] cmd_class,
    input wire cmd_unimpl,
    input wire cmd_seq_bad,
    input wire cmd_is_background,
    input wire cmd_is_cpu_reg,
    input wire cmd_is_step,
    input wire cmd_is_read,
    // Internal access request and its outcome
    input wire acc_start,
    input wire acc_is_write,
    input wire acc_is_mem,
    input wire acc_is_command_b,
    input wire acc_unimpl_addr,
    input wire acc_flash_write,
    input wire acc_bad_reg,
    input wire bus_free,
    input wire acc_done,
    input wire ecc_error,
    input wire [7:0] acc_rdata,
    input wire external_wait,
    // Host retrieval and status write
    input wire host_retrieve,
    input wire csr_wr,
    input wire [3:0] csr_wdata,
    // Controller and device state
    input wire ack_enable,
    input wire cycle_bit_a,
    input wire clock_in_stop_bit,
    input wire ctrl_enabled,
    input wire bdm_active_flag,
    input wire stop_mode,
    input wire wait_mode,
    input wire wait_return_pending,
    input wire secure_at_reset,
    input wire erase_busy,
    input wire erase_done,
    input wire erase_ok,
    // Results
    output reg [7:0] debug_status_low_byte_r,
    output reg [7:0] rdata_r,
    output reg acc_abort_r,
    output reg halt_req_r,
    output reg long_ack_r,
    output reg unsecure_flag_r,
    output reg sec_unlock_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    reg no_response_flag_r;
    reg read_invalid_flag_r;
    reg illegal_access_flag_r;
    reg illegal_command_flag_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg acc_wr_r;
    reg bad_acc_r;
    reg halt_pend_r;
    reg bg_cmd_r;
    reg strap_seen_r;
    reg [`DBGEF_LACK_W-1:0] lack_cnt_r;
    reg nr_set;
    reg abort_req;
    wire illegal_cmd;
    wire tmo_expired;
    wire handshake;
    wire in_flight;
    wire bad_acc_now;

    assign handshake = ack_enable && !cycle_bit_a;
    assign in_flight = (state_r != `DBGEF_ST_IDLE);
    assign bad_acc_now = acc_unimpl_addr || acc_flash_write || acc_bad_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sub blocks

    dbgef_cmd_check u_cmd_check (
        .clk(clk),
        .rst_n(rst_n),
        .cmd_valid(cmd_valid),
        .cmd_class(cmd_class),
        .cmd_unimpl(cmd_unimpl),
        .cmd_seq_bad(cmd_seq_bad),
        .ctrl_enabled(ctrl_enabled),
        .bdm_active_flag(bdm_active_flag),
        .erase_busy(erase_busy),
        .secure(!unsecure_flag_r),
        .illegal_r(illegal_cmd)
    );

    // Timer only runs while a handshaked access awaits a free cycle
    dbgef_timeout u_timeout (
        .clk(clk),
        .rst_n(rst_n),
        .run(state_r == `DBGEF_ST_WAIT && handshake && !bus_free),
        .expired_r(tmo_expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer

    // Idle, waiting for bus cycle/finish, or held by external wait
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `DBGEF_ST_IDLE: begin
                if (acc_start && !bad_acc_now && !(stop_mode && !clock_in_stop_bit))
                    state_nxt = `DBGEF_ST_WAIT;
            end
            `DBGEF_ST_WAIT: begin
                if (acc_done)
                    state_nxt = `DBGEF_ST_IDLE;
                else if (abort_req && external_wait)
                    state_nxt = `DBGEF_ST_HOLD;
                else if (abort_req)
                    state_nxt = `DBGEF_ST_IDLE;
            end
            `DBGEF_ST_HOLD: begin
                if (!external_wait || acc_done)
                    state_nxt = `DBGEF_ST_IDLE;
            end
            default: state_nxt = `DBGEF_ST_IDLE;
        endcase
    end

    // No-response causes; abortable ones also request an abort
    always @* begin
        nr_set = 1'b0;
        abort_req = 1'b0;
        if (state_r == `DBGEF_ST_WAIT && tmo_expired) begin
            nr_set = 1'b1;
            abort_req = 1'b1;
        end
        if (in_flight && !acc_done && !handshake && host_retrieve) begin
            nr_set = 1'b1;
            abort_req = 1'b1;
        end
        if (in_flight && acc_wr_r && !acc_done && cmd_valid) begin
            nr_set = 1'b1;
            abort_req = 1'b1;
        end
        if (acc_start && stop_mode && !clock_in_stop_bit && (acc_is_mem || acc_is_command_b))
            nr_set = 1'b1;
        if (cmd_valid && wait_mode && (cmd_is_background || cmd_is_cpu_reg))
            nr_set = 1'b1;
        if (cmd_valid && wait_return_pending)
            nr_set = 1'b1;
        if (cmd_valid && cmd_is_step && ctrl_enabled && wait_mode)
            nr_set = 1'b1;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `DBGEF_ST_IDLE;
            acc_wr_r <= 1'b0;
            bad_acc_r <= 1'b0;
            acc_abort_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (acc_start) begin
                acc_wr_r <= acc_is_write;
                bad_acc_r <= bad_acc_now;
            end
            // Abort deferred while an external wait stretches the cycle
            acc_abort_r <= (abort_req && !external_wait) ||
                (state_r == `DBGEF_ST_HOLD && !external_wait && !acc_done);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error flags

    // Hardware set wins over a same-cycle write-one clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            no_response_flag_r <= 1'b0;
            read_invalid_flag_r <= 1'b0;
            illegal_access_flag_r <= 1'b0;
            illegal_command_flag_r <= 1'b0;
        end else begin
            if (nr_set || (acc_start && (stop_mode && !clock_in_stop_bit) && acc_is_command_b))
                no_response_flag_r <= 1'b1;
            else if (csr_wr && csr_wdata[`DBGEF_BIT_NORSP_POS])
                no_response_flag_r <= 1'b0;
            if (acc_done && in_flight && !acc_wr_r && ecc_error)
                read_invalid_flag_r <= 1'b1;
            else if (csr_wr && csr_wdata[`DBGEF_BIT_READ_INVALID_POS])
                read_invalid_flag_r <= 1'b0;
            if (acc_start && bad_acc_now)
                illegal_access_flag_r <= 1'b1;
            else if (csr_wr && csr_wdata[`DBGEF_BIT_ILLEGAL_ACCESS_POS])
                illegal_access_flag_r <= 1'b0;
            if (illegal_cmd)
                illegal_command_flag_r <= 1'b1;
            else if (csr_wr && csr_wdata[`DBGEF_BIT_ILLEGAL_COMMAND_POS])
                illegal_command_flag_r <= 1'b0;
        end
    end

    // Status byte mirrors the flags one cycle later; upper bits are not ours
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            debug_status_low_byte_r <= 8'h00;
        end else begin
            debug_status_low_byte_r <= {4'h0, no_response_flag_r, read_invalid_flag_r,
                illegal_access_flag_r, illegal_command_flag_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Returned data

    // Filler replaces data on failed or illegal access; ECC error keeps data
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (no_response_flag_r) begin
            rdata_r <= `DBGEF_FILL_BYTE;
        end else if (bad_acc_r) begin
            rdata_r <= `DBGEF_FILL_BYTE;
        end else if (illegal_command_flag_r && cmd_is_read) begin
            rdata_r <= `DBGEF_FILL_BYTE;
        end else if (acc_done && in_flight && !acc_wr_r) begin
            rdata_r <= acc_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Halt request and long acknowledge

    // Background request in wait is kept and completes on wait exit
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bg_cmd_r <= 1'b0;
            halt_pend_r <= 1'b0;
            halt_req_r <= 1'b0;
        end else begin
            // Legality verdict lands a cycle after the command, so wait for it
            bg_cmd_r <= cmd_valid && cmd_is_background && ctrl_enabled;
            if (bg_cmd_r && !illegal_cmd)
                halt_pend_r <= 1'b1;
            else if (halt_req_r)
                halt_pend_r <= 1'b0;
            halt_req_r <= halt_pend_r && !wait_mode && !halt_req_r;
        end
    end

    // Long pulse flags a timeout abort to the host when handshaking
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lack_cnt_r <= {`DBGEF_LACK_W{1'b0}};
            long_ack_r <= 1'b0;
        end else if (state_r == `DBGEF_ST_WAIT && tmo_expired && handshake) begin
            lack_cnt_r <= `DBGEF_LACK_CYCLES;
            long_ack_r <= 1'b1;
        end else if (lack_cnt_r != {`DBGEF_LACK_W{1'b0}}) begin
            lack_cnt_r <= lack_cnt_r - {{(`DBGEF_LACK_W-1){1'b0}}, 1'b1};
            long_ack_r <= (lack_cnt_r != {{(`DBGEF_LACK_W-1){1'b0}}, 1'b1});
        end else begin
            long_ack_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Security

    // Secure strap is caught on the first clock after reset release
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_seen_r <= 1'b0;
            unsecure_flag_r <= 1'b0;
            sec_unlock_r <= 1'b0;
        end else begin
            sec_unlock_r <= 1'b0;
            if (!strap_seen_r) begin
                strap_seen_r <= 1'b1;
                unsecure_flag_r <= !secure_at_reset;
            end else if (erase_done && erase_ok) begin
                unsecure_flag_r <= 1'b1;
                sec_unlock_r <= 1'b1;
            end
            // Failed erase leaves the flag as it is, device stays locked
        end
    end

endmodule

// [dbgef_bus_model.sv]
// Internal bus resource model that answers debug accesses
`timescale 1ns/1ps
module dbgef_bus_model (
    input wire clk,
    input wire rst_n,
    input wire acc_start,
    input wire abort_in,
    input wire ign_in,
    input wire busy_in,
    input wire ecc_in,
    input wire [3:0] dly_in,
    input wire [7:0] data_in,
    output logic bus_free,
    output logic acc_done,
    output logic ecc_error,
    output logic [7:0] acc_rdata
);
    logic [3:0] cnt_r;
    logic pend_r;
    // A busy application loop leaves no free slot
    assign bus_free = !busy_in;
    // One access at a time; idle data toggles so a stale byte never looks valid
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            pend_r <= 1'b0;
            acc_done <= 1'b0;
            ecc_error <= 1'b0;
            acc_rdata <= 8'h00;
        end else begin
            acc_done <= 1'b0;
            ecc_error <= 1'b0;
            acc_rdata <= ~acc_rdata;
            if (acc_start && !ign_in) begin
                pend_r <= 1'b1;
                cnt_r <= dly_in;
            end else if (abort_in) begin
                pend_r <= 1'b0;
            end else if (pend_r && !busy_in) begin
                cnt_r <= cnt_r - 4'h1;
                if (cnt_r == 4'h0) begin
                    pend_r <= 1'b0;
                    acc_done <= 1'b1;
                    ecc_error <= ecc_in;
                    acc_rdata <= data_in;
                end
            end
        end
    end
endmodule

// [dbgef_properties.sv]
// Assertion checker for the debug error flag block, bound to its top
`timescale 1ns/1ps
module dbgef_properties (
    input wire clk,
    input wire rst_n,
    input wire acc_start,
    input wire acc_unimpl_addr,
    input wire acc_flash_write,
    input wire acc_bad_reg,
    input wire bus_free,
    input wire acc_done,
    input wire ecc_error,
    input wire ack_enable,
    input wire cycle_bit_a,
    input wire csr_wr,
    input wire [3:0] csr_wdata,
    input wire erase_done,
    input wire erase_ok,
    input wire [7:0] debug_status_low_byte_r,
    input wire [7:0] rdata_r,
    input wire long_ack_r,
    input wire unsecure_flag_r,
    input wire sec_unlock_r
);
    logic [9:0] wcnt_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Accesses that must be refused, and a successful erase outcome
    sequence s_bad_acc;
        acc_start && (acc_unimpl_addr || acc_flash_write || acc_bad_reg);
    endsequence
    sequence s_erase_ok;
        erase_done && erase_ok;
    endsequence
    // Cycles spent waiting for a free slot; drops to zero at the top, restarts only when a new access starts
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            wcnt_r <= 10'h000;
        else if (acc_start && ack_enable && !cycle_bit_a && !bus_free)
            wcnt_r <= 10'h001;
        else if (wcnt_r != 10'h000 && wcnt_r != 10'h3FF && !bus_free && !acc_done && ack_enable && !cycle_bit_a)
            wcnt_r <= wcnt_r + 10'h001;
        else
            wcnt_r <= 10'h000;
    end
    illegal_access_flag_set_a: assert property (s_bad_acc |-> ##2 debug_status_low_byte_r[1])
        else $error("illegal access flag not set");
    fill_byte_a: assert property (s_bad_acc |-> ##2 rdata_r == 8'hEE)
        else $error("filler byte missing");
    flag_sticky_a: assert property (debug_status_low_byte_r[1] && !csr_wr && !$past(csr_wr)
        |=> debug_status_low_byte_r[1]) else $error("flag dropped without clear");
    flag_clear_a: assert property (csr_wr && csr_wdata[2] && !(acc_done && ecc_error)
        |-> ##2 !debug_status_low_byte_r[2]) else $error("flag not cleared");
    erase_unlock_a: assert property (s_erase_ok |=> unsecure_flag_r && sec_unlock_r)
        else $error("erase did not unsecure");
    erase_fail_a: assert property (erase_done && !erase_ok && !unsecure_flag_r |=> !unsecure_flag_r && !sec_unlock_r)
        else $error("failed erase unsecured");
    tmo_limit_a: assert property (wcnt_r == 10'h1F4 |-> !long_ack_r ##[10:20] long_ack_r)
        else $error("timeout not at limit");
    long_ack_len_a: assert property ($rose(long_ack_r) |-> long_ack_r [*8] ##1 !long_ack_r)
        else $error("long ack width wrong");
endmodule
bind dbgef_core dbgef_properties u_props (.*);

// [tb.sv]
// Self-checking testbench for the debug error flag and security gate block
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, cmd_valid, cmd_unimpl, cmd_seq_bad, cmd_is_background, cmd_is_cpu_reg, cmd_is_step;
    logic cmd_is_read, acc_start, acc_is_write, acc_is_mem, acc_is_command_b, acc_unimpl_addr, acc_flash_write;
    logic acc_bad_reg, external_wait, host_retrieve, csr_wr, ack_enable, cycle_bit_a, clock_in_stop_bit;
    logic ctrl_enabled, bdm_active_flag, stop_mode, wait_mode, wait_return_pending, secure_at_reset;
    logic erase_busy, erase_done, erase_ok, busy_in, ecc_in;
    logic [1:0] cmd_class;
    logic [3:0] csr_wdata, dly_in;
    logic [7:0] data_in, d;
    wire bus_free, acc_done, ecc_error, acc_abort_r, halt_req_r, long_ack_r, unsecure_flag_r, sec_unlock_r;
    wire [7:0] acc_rdata, debug_status_low_byte_r, rdata_r;
    typedef struct packed {logic [2:0] sel; logic [7:0] val;} dbgef_note_t;
    dbgef_note_t q[$];
    dbgef_note_t nt;
    int mismatches, n_compared, i, k;
    logic [7:0] ctab [7] = '{8'h2D, 8'h5D, 8'h85, 8'h49, 8'h4F, 8'h8C, 8'h0A};
    dbgef_core uut (.*);
    dbgef_bus_model u_bus (.clk(clk), .rst_n(rst_n), .acc_start(acc_start), .abort_in(acc_abort_r),
        .ign_in(acc_unimpl_addr | acc_flash_write | acc_bad_reg), .busy_in(busy_in), .ecc_in(ecc_in),
        .dly_in(dly_in), .data_in(data_in), .bus_free(bus_free), .acc_done(acc_done),
        .ecc_error(ecc_error), .acc_rdata(acc_rdata));
    // Core clock, 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pick(input logic [2:0] s);
        case (s)
            3'h0: pick = debug_status_low_byte_r;
            3'h1: pick = rdata_r;
            3'h2: pick = {7'h00, unsecure_flag_r};
            default: pick = {7'h00, halt_req_r};
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One note per cycle keeps the watcher in step with the queue
    task automatic note(input logic [2:0] s, input logic [7:0] v);
        q.push_back({s, v});
        tick(1);
    endtask
    task automatic command(input logic [1:0] c, input logic [5:0] f);
        cmd_class = c;
        {cmd_unimpl, cmd_seq_bad, cmd_is_background, cmd_is_cpu_reg, cmd_is_step, cmd_is_read} = f;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
    endtask
    task automatic access(input logic [5:0] f);
        {acc_is_write, acc_is_mem, acc_is_command_b, acc_unimpl_addr, acc_flash_write, acc_bad_reg} = f;
        acc_start = 1'b1;
        tick(1);
        acc_start = 1'b0;
        {acc_is_write, acc_is_mem, acc_is_command_b, acc_unimpl_addr, acc_flash_write, acc_bad_reg} = 6'h00;
    endtask
    task automatic clear(input logic [3:0] w);
        csr_wr = 1'b1;
        csr_wdata = w;
        tick(1);
        csr_wr = 1'b0;
        tick(1);
    endtask
    task automatic erase(input logic ok);
        erase_busy = 1'b1;
        tick(3);
        erase_busy = 1'b0;
        erase_ok = ok;
        erase_done = 1'b1;
        tick(1);
        erase_done = 1'b0;
        tick(2);
    endtask
    // Flag seen, still held later, then cleared by the host
    task automatic flag_chk(input logic [7:0] v);
        tick(4);
        note(3'h0, v);
        tick(20);
        note(3'h0, v);
        clear(4'hF);
        tick(2);
        note(3'h0, 8'h00);
    endtask
    // Results are compared on the rising edge, from values settled at the fall
    always @(posedge clk) begin
        if (q.size() > 0) begin
            nt = q.pop_front();
            check(pick(nt.sel), nt.val);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {cmd_valid, cmd_class, cmd_unimpl, cmd_seq_bad, cmd_is_background, cmd_is_cpu_reg, cmd_is_step} = '0;
        {cmd_is_read, acc_start, acc_is_write, acc_is_mem, acc_is_command_b, acc_unimpl_addr} = '0;
        {acc_flash_write, acc_bad_reg, external_wait, host_retrieve, csr_wr, csr_wdata, cycle_bit_a} = '0;
        {stop_mode, wait_mode, wait_return_pending, erase_busy, erase_done, erase_ok, busy_in, ecc_in} = '0;
        {ack_enable, clock_in_stop_bit, ctrl_enabled, bdm_active_flag, secure_at_reset} = 5'h1F;
        data_in = 8'h00;
        dly_in = 4'h2;
        rst_n = 1'b0;
        void'($urandom(32'h57d4_8d44));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        tick(2);
        note(3'h2, 8'h00);
        command(2'h1, 6'h01);
        tick(4);
        note(3'h0, 8'h01);
        note(3'h1, 8'hEE);
        clear(4'hF);
        erase(1'b0);
        note(3'h2, 8'h00);
        erase(1'b1);
        note(3'h2, 8'h01);
        for (i = 0; i < 7; i++) begin
            {bdm_active_flag, ctrl_enabled, erase_busy} = ctab[i][3:1];
            command(ctab[i][7:6], {ctab[i][5:4], 4'h0});
            flag_chk({7'h00, ctab[i][0]});
        end
        {bdm_active_flag, ctrl_enabled, erase_busy} = 3'h6;
        for (i = 0; i < 3; i++) begin
            access(6'h10 | (6'h04 >> i) | (i == 1 ? 6'h20 : 6'h00));
            tick(4);
            note(3'h1, 8'hEE);
            note(3'h0, 8'h02);
            clear(4'hD);
            tick(2);
            note(3'h0, 8'h02);
            clear(4'h2);
            tick(2);
            note(3'h0, 8'h00);
        end
        for (i = 0; i < 2; i++) begin
            d = 8'($urandom);
            data_in = d;
            ecc_in = i[0];
            access(6'h10);
            k = 0;
            while (acc_done !== 1'b1 && k < 40) begin
                tick(1);
                k++;
            end
            tick(3);
            note(3'h0, {5'h00, i[0], 2'h0});
            note(3'h1, d);
            clear(4'h4);
        end
        busy_in = 1'b1;
        access(6'h10);
        k = 1;
        while (long_ack_r !== 1'b1 && k < 700) begin
            tick(1);
            k++;
        end
        check({7'h00, k >= 512 && k <= 520}, 8'h01);
        k = 0;
        while (long_ack_r === 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        check(8'(k), 8'h08);
        busy_in = 1'b0;
        note(3'h1, 8'hEE);
        flag_chk(8'h08);
        ack_enable = 1'b0;
        dly_in = 4'hF;
        access(6'h10);
        host_retrieve = 1'b1;
        tick(1);
        host_retrieve = 1'b0;
        flag_chk(8'h08);
        external_wait = 1'b1;
        access(6'h10);
        host_retrieve = 1'b1;
        tick(1);
        host_retrieve = 1'b0;
        tick(2);
        check({7'h00, acc_abort_r}, 8'h00);
        external_wait = 1'b0;
        tick(1);
        check({7'h00, acc_abort_r}, 8'h01);
        flag_chk(8'h08);
        access(6'h30);
        command(2'h0, 6'h00);
        flag_chk(8'h08);
        ack_enable = 1'b1;
        dly_in = 4'h2;
        stop_mode = 1'b1;
        clock_in_stop_bit = 1'b0;
        access(6'h08);
        flag_chk(8'h08);
        stop_mode = 1'b0;
        clock_in_stop_bit = 1'b1;
        wait_mode = 1'b1;
        command(2'h1, 6'h08);
        flag_chk(8'h08);
        command(2'h2, 6'h04);
        flag_chk(8'h08);
        wait_mode = 1'b0;
        k = 0;
        while (halt_req_r !== 1'b1 && k < 10) begin
            tick(1);
            k++;
        end
        check({7'h00, k < 10}, 8'h01);
        wait_return_pending = 1'b1;
        command(2'h0, 6'h00);
        flag_chk(8'h08);
        wait_return_pending = 1'b0;
        wait_mode = 1'b1;
        command(2'h2, 6'h02);
        flag_chk(8'h08);
        wait_mode = 1'b0;
        // Second reset with the strap open: the flag must come up set
        rst_n = 1'b0;
        secure_at_reset = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(2);
        note(3'h2, 8'h01);
        tick(2);
        wrap_up();
    end
    // Watchdog sized well above the expected run length
    initial begin
        repeat (8000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
